// ### rtl/cca_pkg.sv
// What this block does
// - An input word takes one cycle at 8 bits, two at 16, four at 32.
// - Width field 00/01/10/11 selects 8/16/24/32-bit input words.
// - Bit-order control 1 feeds input bits reversed across the selected width.
// - Result and seed keep bit 31 as MSB whatever the bit order.
// - Checksum adds the previous carry when discard is 0, drops it when 1.
// - Seed-load control 1 stores the written word as the new running seed.
// - Mode 000 disables the block; 001 is 8-bit, 010 is 32-bit checksum.
// - Modes 011/100/101 are CRC-16 0x8005, CRC-16 0x1021, CRC-32; 110 reserved.
// - Writing mode 111 clears state and restores the default seed.
// - Busy flag reads 1 while a calculation is in progress.
// - Writing the lowest data byte starts the calculation on the word.
package cca_pkg;
    localparam int CCA_AW = 20;
    // Register indices and their word byte addresses
    localparam logic [15:0] CCA_CFG_IDX = 16'ha078;
    localparam logic [15:0] CCA_DATA0_IDX = 16'ha07c;
    localparam logic [15:0] CCA_DATA1_IDX = 16'ha07d;
    localparam logic [15:0] CCA_DATA2_IDX = 16'ha07e;
    localparam logic [15:0] CCA_DATA3_IDX = 16'ha07f;
    localparam logic [CCA_AW-1:0] CCA_CFG_ADDR = {2'b00, CCA_CFG_IDX, 2'b00};
    localparam logic [CCA_AW-1:0] CCA_DATA0_ADDR = {2'b00, CCA_DATA0_IDX, 2'b00};
    localparam logic [CCA_AW-1:0] CCA_DATA1_ADDR = {2'b00, CCA_DATA1_IDX, 2'b00};
    localparam logic [CCA_AW-1:0] CCA_DATA2_ADDR = {2'b00, CCA_DATA2_IDX, 2'b00};
    localparam logic [CCA_AW-1:0] CCA_DATA3_ADDR = {2'b00, CCA_DATA3_IDX, 2'b00};
    // Configuration field positions
    localparam int CCA_WIDTH_LSB = 6;
    localparam int CCA_REVERSE_BIT = 5;
    localparam int CCA_DISCARD_BIT = 4;
    localparam int CCA_SEED_BIT = 3;
    localparam int CCA_BUSY_BIT = 0;
    localparam logic [7:0] CCA_CFG_RESET = 8'h00;
    localparam logic [31:0] CCA_DATA_RESET = 32'h0000_0000;
    // Mode codes
    localparam logic [2:0] CCA_MODE_OFF = 3'h0;
    localparam logic [2:0] CCA_MODE_CHK8 = 3'h1;
    localparam logic [2:0] CCA_MODE_CHK32 = 3'h2;
    localparam logic [2:0] CCA_MODE_CRC16A = 3'h3;
    localparam logic [2:0] CCA_MODE_CRC16B = 3'h4;
    localparam logic [2:0] CCA_MODE_CRC32 = 3'h5;
    localparam logic [2:0] CCA_MODE_CLEAR = 3'h7;
    // Polynomials without the top term, and default seeds
    localparam logic [31:0] CCA_POLY16A = 32'h0000_8005;
    localparam logic [31:0] CCA_POLY16B = 32'h0000_1021;
    localparam logic [31:0] CCA_POLY32 = 32'h04c1_1db7;
    localparam logic [31:0] CCA_SEED_CRC16 = 32'h0000_ffff;
    localparam logic [31:0] CCA_SEED_CRC32 = 32'hffff_ffff;
    localparam logic [31:0] CCA_SEED_CHK = 32'h0000_0000;
    typedef enum logic [1:0] {
        cca_idle = 2'b01,
        cca_run = 2'b10
    } cca_state_type;
endpackage : cca_pkg

// ### rtl/cca_accel.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module cca_accel (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [cca_pkg::CCA_AW-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic busy // Calculation in progress
);
    import cca_pkg::*;

    logic [1:0] input_width;
    logic reverse;
    logic discard_carry;
    logic seed_load;
    logic [2:0] calc_mode_select;
    logic [31:8] high_bytes;
    logic [31:0] result;
    logic carry;
    logic [31:0] calc_input_word;
    logic [1:0] step;
    logic [1:0] last_step;
    cca_state_type state;

    // Reverse the low n bits of a word, upper bits zero
    function automatic logic [31:0] rev_bits(input logic [31:0] w, input logic [1:0] wsel);
        logic [31:0] r;
        int n;
        r = '0;
        n = 8 * (int'(wsel) + 1);
        for (int i = 0; i < 32; i++) begin
            if (i < n) begin
                r[i] = w[n - 1 - i];
            end
        end
        return r;
    endfunction : rev_bits

    // Mask a word to the selected width
    function automatic logic [31:0] width_mask(input logic [1:0] wsel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            m[i] = (i < 8 * (int'(wsel) + 1));
        end
        return m;
    endfunction : width_mask

    // Eight CRC steps, bit 0 of the byte first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
                                              input logic [31:0] poly, input logic w16);
        logic [31:0] x;
        logic fb;
        x = c;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = b[i] ^ (w16 ? x[15] : x[31]);
            x = {x[30:0], 1'b0};
            if (fb) begin
                x = x ^ poly;
            end
            if (w16) begin
                x = x & CCA_SEED_CRC16;
            end
        end
        return x;
    endfunction : crc_byte

    // Address decode
    wire is_cfg = (paddr == CCA_CFG_ADDR);
    wire is_d0 = (paddr == CCA_DATA0_ADDR);
    wire is_d1 = (paddr == CCA_DATA1_ADDR);
    wire is_d2 = (paddr == CCA_DATA2_ADDR);
    wire is_d3 = (paddr == CCA_DATA3_ADDR);
    wire is_data = is_d0 | is_d1 | is_d2 | is_d3;
    wire mapped = is_cfg | is_data;

    // Data access and config writes wait while busy; status reads never wait
    wire stall = busy & (is_data | (is_cfg & pwrite));
    assign pready = ~stall;
    wire xfer = psel & penable & pready;
    assign pslverr = xfer & ~mapped;
    wire wr = xfer & pwrite & mapped;
    wire cfg_wr = wr & is_cfg;
    wire d0_wr = wr & is_d0;

    // Mode decode
    wire mode_on = (calc_mode_select >= CCA_MODE_CHK8) & (calc_mode_select <= CCA_MODE_CRC32);
    wire is_crc16 = (calc_mode_select == CCA_MODE_CRC16A) | (calc_mode_select == CCA_MODE_CRC16B);
    wire is_crc = is_crc16 | (calc_mode_select == CCA_MODE_CRC32);
    wire clear_wr = cfg_wr & (pwdata[2:0] == CCA_MODE_CLEAR);
    wire [31:0] clear_seed = is_crc16 ? CCA_SEED_CRC16 :
                             (is_crc ? CCA_SEED_CRC32 : CCA_SEED_CHK);

    // Word assembly: the high bytes held, the low byte from this write
    wire [31:0] accel_data_word = {high_bytes, pwdata[7:0]} & width_mask(input_width);
    wire seed_wr = d0_wr & seed_load & mode_on;
    wire start = d0_wr & ~seed_load & mode_on;
    wire [31:0] next_input = reverse ? rev_bits(accel_data_word, input_width)
                                     : accel_data_word;

    // One byte of the input word per cycle
    wire [7:0] cur_byte = calc_input_word[8 * step +: 8];
    wire cin = carry & ~discard_carry;
    wire [8:0] sum8 = {1'b0, result[7:0]} + {1'b0, cur_byte} + {8'h00, cin};
    wire [31:0] shifted = {24'h00_0000, cur_byte} << (8 * step);
    wire [32:0] sum32 = {1'b0, result} + {1'b0, shifted} + {32'h0000_0000, cin};
    wire [31:0] poly = (calc_mode_select == CCA_MODE_CRC16A) ? CCA_POLY16A :
                       ((calc_mode_select == CCA_MODE_CRC16B) ? CCA_POLY16B : CCA_POLY32);
    wire [31:0] crc_next = crc_byte(result, cur_byte, poly, is_crc16);
    wire [31:0] next_result = is_crc ? crc_next :
                              ((calc_mode_select == CCA_MODE_CHK8) ? {24'h00_0000, sum8[7:0]}
                                                                    : sum32[31:0]);
    wire next_carry = (calc_mode_select == CCA_MODE_CHK8) ? sum8[8] : sum32[32];

    assign busy = (state == cca_run);

    // Configuration register; code 111 clears without changing the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_width <= CCA_CFG_RESET[CCA_WIDTH_LSB +: 2];
            reverse <= CCA_CFG_RESET[CCA_REVERSE_BIT];
            discard_carry <= CCA_CFG_RESET[CCA_DISCARD_BIT];
            seed_load <= CCA_CFG_RESET[CCA_SEED_BIT];
            calc_mode_select <= CCA_CFG_RESET[2:0];
        end else if (cfg_wr) begin
            input_width <= pwdata[CCA_WIDTH_LSB +: 2];
            reverse <= pwdata[CCA_REVERSE_BIT];
            discard_carry <= pwdata[CCA_DISCARD_BIT];
            seed_load <= pwdata[CCA_SEED_BIT];
            if (pwdata[2:0] != CCA_MODE_CLEAR) begin
                calc_mode_select <= pwdata[2:0];
            end
        end
    end

    // High data bytes wait for the low byte write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_bytes <= CCA_DATA_RESET[31:8];
        end else if (wr) begin
            if (is_d1) high_bytes[15:8] <= pwdata[7:0];
            if (is_d2) high_bytes[23:16] <= pwdata[7:0];
            if (is_d3) high_bytes[31:24] <= pwdata[7:0];
        end
    end

    // Sequencer: idle until the low byte write, then one byte per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cca_idle;
            step <= 2'd0;
            last_step <= 2'd0;
            calc_input_word <= CCA_DATA_RESET;
        end else begin
            unique case (state)
                cca_idle: begin
                    if (start) begin
                        state <= cca_run;
                        step <= 2'd0;
                        last_step <= input_width;
                        calc_input_word <= next_input;
                    end
                end
                cca_run: begin
                    step <= step + 2'd1;
                    if (step == last_step) begin
                        state <= cca_idle;
                    end
                end
                default: state <= cca_idle;
            endcase
        end
    end

    // Running result and carry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= CCA_DATA_RESET;
            carry <= 1'b0;
        end else if (clear_wr) begin
            result <= clear_seed;
            carry <= 1'b0;
        end else if (seed_wr) begin
            result <= accel_data_word;
            carry <= 1'b0;
        end else if (busy && mode_on) begin
            result <= next_result;
            carry <= next_carry;
        end
    end

    // Read mux, result keeps its natural bit order
    wire [7:0] cfg_rd = {input_width, reverse, discard_carry, seed_load, 2'b00, busy};
    wire [7:0] data_rd = is_d0 ? result[7:0] : (is_d1 ? result[15:8] :
                         (is_d2 ? result[23:16] : result[31:24]));
    wire [31:0] next_prdata = is_cfg ? {24'h00_0000, cfg_rd} :
                              (is_data ? {24'h00_0000, data_rd} : 32'h0000_0000);

    // Read data captured every selected cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel) begin
            prdata <= next_prdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Word starts by selected width
    sequence start_byte_s;
        start && input_width == 2'b00;
    endsequence

    sequence start_tri_s;
        start && input_width == 2'b10;
    endsequence

    // Engine back to idle one cycle on
    sequence done_s;
        ##1 !busy;
    endsequence

    // Access phase to a data register
    sequence data_access_s;
        psel && penable && is_data;
    endsequence

    byte_time_a: assert property (start && input_width == 2'b00 |=> busy ##1 !busy)
        else $error("8-bit word not done in one cycle");
    half_time_a: assert property (start && input_width == 2'b01 |=> busy [*2] ##1 !busy)
        else $error("16-bit word not done in two cycles");
    word_time_a: assert property (start && input_width == 2'b11 |=> busy [*4] ##1 !busy)
        else $error("32-bit word not done in four cycles");
    clear_seed_a: assert property (clear_wr |=> result == $past(clear_seed))
        else $error("clear did not restore default seed");
    seed_entry_a: assert property (seed_wr |=> result == $past(accel_data_word) && !busy)
        else $error("seed not stored unchanged");
    mode_off_a: assert property (calc_mode_select == CCA_MODE_OFF && !clear_wr
                                 |=> $stable(result))
        else $error("result changed while disabled");
    chk8_step_a: assert property (busy && calc_mode_select == CCA_MODE_CHK8 && discard_carry
        |=> result[7:0] == 8'($past(result[7:0]) + $past(cur_byte)))
        else $error("checksum without carry wrong");
    busy_read_a: assert property (psel && !penable && is_cfg && !pwrite && busy
                                  ##1 pready |-> prdata[CCA_BUSY_BIT])
        else $error("busy flag not read as one");

    // Byte word through the named sequences
    byte_seq_a: assert property (start_byte_s |=> busy ##0 done_s)
        else $error("8-bit word timing wrong");

    // Three byte word takes three cycles
    tri_time_a: assert property (start_tri_s |=> busy [*3] ##0 done_s)
        else $error("24-bit word not done in three cycles");

    // A started word always raises busy
    start_busy_a: assert property (start |=> busy)
        else $error("low byte write did not start");

    // Data access waits while a word runs
    data_stall_a: assert property (data_access_s and busy |-> !pready)
        else $error("data access not held while busy");

    // Idle engine never inserts wait states
    idle_ready_a: assert property (!busy |-> pready)
        else $error("wait state while idle");

    // Unmapped access answers with an error
    bad_addr_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");

    // Error only for unmapped addresses
    err_map_a: assert property (pslverr |-> !mapped)
        else $error("error on a mapped address");

    // Upper read data bits stay zero
    rd_upper_a: assert property (prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    // Clear also drops the stored carry
    clear_carry_a: assert property (clear_wr |=> !carry)
        else $error("carry kept over clear");

    // Disabled engine never starts
    off_idle_a: assert property (!mode_on && !busy |=> !busy)
        else $error("disabled engine became busy");

    // Reversed order fed to the engine
    reverse_in_a: assert property (start && reverse
        |=> calc_input_word == $past(rev_bits(accel_data_word, input_width)))
        else $error("input not reversed across width");

    // Configuration frozen during a word
    cfg_hold_a: assert property (busy |=> $stable(input_width) && $stable(calc_mode_select))
        else $error("configuration changed mid-word");

    // Wide checksum without carry
    chk32_step_a: assert property (busy && calc_mode_select == CCA_MODE_CHK32 && discard_carry
        |=> result == 32'($past(result) + $past(shifted)))
        else $error("32-bit checksum without carry wrong");

    // Narrow checksum with carry added back
    carry_add_a: assert property (busy && calc_mode_select == CCA_MODE_CHK8 && !discard_carry
        |=> result[7:0] == 8'($past(result[7:0]) + $past(cur_byte) + $past(carry)))
        else $error("checksum with carry wrong");

    // CRC-16 result kept to 16 bits
    crc16_top_a: assert property (busy && is_crc16 |=> result[31:16] == 16'h0000)
        else $error("CRC-16 result wider than 16 bits");
endmodule : cca_accel

// ### bench/cca_cpu_model.sv
`timescale 1ns/1ps
// CPU side of the register bus, one APB transfer at a time
module cca_cpu_model (
    input wire logic pclk, // System clock
    input wire logic pready, // Slave ready
    input wire logic pslverr, // Slave error
    input wire logic [31:0] prdata, // Read data
    output logic psel, // Select
    output logic penable, // Access phase
    output logic pwrite, // Direction
    output logic [cca_pkg::CCA_AW-1:0] paddr, // Byte address
    output logic [31:0] pwdata // Write data
);
    import cca_pkg::*;
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h0_0000;
        pwdata = 32'h0000_0000;
    end
    // Setup cycle, then access held until pready is seen high
    task automatic xfer(input logic wr, input logic [CCA_AW-1:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic err, output logic tmo);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        tmo = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cca_cpu_model

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import cca_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, err, tmo, m_cy;
    logic [CCA_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, res, m_res, v, mask, rng;
    logic [7:0] cfg;
    logic [2:0] m_mode;
    int errors, n_compared, nb;
    // Free-running system clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    cca_accel cca_accel_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    cca_cpu_model cca_cpu_model_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    // Xorshift source of stimulus
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [CCA_AW-1:0] a, input logic [7:0] d);
        cca_cpu_model_inst.xfer(wr, a, d, rd, err, tmo);
        if (tmo) begin
            errors++;
            complete_run();
        end
    endtask : bus
    // High bytes first, low byte last starts the word
    task automatic put_word(input logic [31:0] w);
        for (int b = int'(cfg[7:6]); b >= 1; b--) bus(1'b1, CCA_DATA0_ADDR + 20'(4 * b), w[8*b+:8]);
        bus(1'b1, CCA_DATA0_ADDR, w[7:0]);
    endtask : put_word
    task automatic get_res();
        for (int b = 0; b < 4; b++) begin
            bus(1'b0, CCA_DATA0_ADDR + 20'(4 * b), 8'h00);
            res[8*b+:8] = rd[7:0];
        end
    endtask : get_res
    // Reference step over one input word
    function automatic void mstep(input logic [31:0] din);
        logic [31:0] w;
        logic [32:0] s;
        logic fb;
        int n, sh;
        n = (int'(cfg[7:6]) + 1) * 8;
        w = 32'h0000_0000;
        for (int i = 0; i < n; i++) w[i] = cfg[5] ? din[n-1-i] : din[i];
        for (int i = 0; i < n; i++) begin
            if (m_mode == CCA_MODE_CRC32) begin
                fb = m_res[31] ^ w[i];
                m_res = {m_res[30:0], 1'b0} ^ (fb ? CCA_POLY32 : 32'h0000_0000);
            end else if (m_mode == CCA_MODE_CRC16A || m_mode == CCA_MODE_CRC16B) begin
                fb = m_res[15] ^ w[i];
                s[31:0] = (m_mode == CCA_MODE_CRC16A) ? CCA_POLY16A : CCA_POLY16B;
                m_res = ({m_res[30:0], 1'b0} ^ (fb ? s[31:0] : 32'h0000_0000)) & 32'h0000_ffff;
            end
        end
        for (int k = 0; k < n / 8; k++) begin
            sh = (m_mode == CCA_MODE_CHK8) ? 0 : 8 * k;
            s = {1'b0, m_res} + ({25'h000_0000, w[8*k+:8]} << sh) + (cfg[4] ? 33'h0 : 33'(m_cy));
            if (m_mode == CCA_MODE_CHK8) begin
                m_res = {24'h00_0000, s[7:0]};
                m_cy = s[8];
            end else if (m_mode == CCA_MODE_CHK32) begin
                m_res = s[31:0];
                m_cy = s[32];
            end
        end
    endfunction : mstep
    initial begin
        presetn = 1'b0;
        errors = 0;
        n_compared = 0;
        rng = 32'd97768;
        cfg = 8'h00;
        m_cy = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped address
        bus(1'b0, CCA_CFG_ADDR, 8'h00);
        chk("cfg reset", {24'h00_0000, CCA_CFG_RESET}, rd);
        get_res();
        chk("data reset", CCA_DATA_RESET, res);
        bus(1'b0, 20'h0_0100, 8'h00);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        $display("reset test done");
        // Every calculation mode 001 to 101 and width, random order and carry handling
        for (int md = 1; md <= 5; md++) begin
            for (int wd = 0; wd < 4; wd++) begin
                v = rnd();
                cfg = {2'(wd), v[1:0], 1'b0, 3'(md)};
                m_mode = 3'(md);
                bus(1'b1, CCA_CFG_ADDR, cfg);
                bus(1'b1, CCA_CFG_ADDR, {cfg[7:3], CCA_MODE_CLEAR});
                m_res = (md == 5) ? CCA_SEED_CRC32 : (md >= 3 ? CCA_SEED_CRC16 : CCA_SEED_CHK);
                m_cy = 1'b0;
                repeat (2) begin
                    v = rnd();
                    put_word(v);
                    #1;
                    nb = 0;
                    while (busy === 1'b1 && nb < 10) begin
                        @(posedge pclk);
                        #1;
                        nb++;
                    end
                    chk("busy cycles", 32'(wd + 1), 32'(nb));
                    mstep(v);
                end
                get_res();
                chk("result", m_res, res);
                bus(1'b0, CCA_CFG_ADDR, 8'h00);
                chk("cfg readback", {24'h00_0000, cfg[7:3], 3'b000}, rd);
                // Seed entry ignores bit order
                cfg[3] = 1'b1;
                bus(1'b1, CCA_CFG_ADDR, cfg);
                v = rnd();
                put_word(v);
                mask = 32'hffff_ffff >> (8 * (3 - wd));
                get_res();
                chk("seed", v & mask, res);
                $display("mode %0d width %0d done", md, wd);
            end
        end
        // Flag read back while a word is in flight
        cfg = {2'b11, 3'b000, CCA_MODE_CRC32};
        bus(1'b1, CCA_CFG_ADDR, cfg);
        put_word(rnd());
        bus(1'b0, CCA_CFG_ADDR, 8'h00);
        chk("busy flag", 32'h0000_0001, {31'h0, rd[0]});
        get_res();
        m_res = res;
        // Disabled and reserved codes leave the result alone
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, CCA_CFG_ADDR, {cfg[7:3], (c == 0) ? CCA_MODE_OFF : 3'b110});
            put_word(rnd());
            #1;
            chk("busy when off", 32'h0000_0000, {31'h0, busy});
            get_res();
            chk("result when off", m_res, res);
        end
        $display("disabled test done");
        complete_run();
    end
endmodule : tb
